// File: tb_touch_sensor_bus_cascade.sv
// bench: writes, direct reads, two-chip cascade, sample clocks, interrupts
`timescale 1ns/1ps
module tb_touch_sensor_bus_cascade;
   import tsbc_pkg::*;
   localparam int SH = 2;
   logic clock, lclk, rst_n, clk_en, sel, role, casc, own1, own2, irq_in;
   logic scl, m_oe_n, ack, ovl, drv1, so1;
   logic oe1_n, oe2_n, int1, int2, sclk1, sclk2, wv1, wv2;
   logic [7:0] touch1, touch2, rd, st1, st2;
   tsbc_wr_t wr1, wr2, wr_last;
   int fails, samples_checked, nwr;
   // open-drain line with pull-up: low if anyone pulls
   wire logic sda = m_oe_n & oe1_n & oe2_n;

   tsbc_slave #(.SAMP_HALF(SH)) dut_u (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .scl_i(scl),
      .sda_i(sda), .sda_o(so1), .sda_oe_n(oe1_n), .address_select_pin(sel), .role_secondary(role),
      .cascade_en(casc), .samp_clk_in(1'b0), .samp_clk_out(sclk1), .sensor_in(touch1), .own_irq(own1),
      .int_in(irq_in), .int_out(int1), .wr_valid(wv1), .wr(wr1), .sensor_state_reg(st1));
   // second chip is always the secondary; its link clock comes from the bench
   tsbc_slave #(.SAMP_HALF(SH)) dut2_u (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .scl_i(scl),
      .sda_i(sda), .sda_o(), .sda_oe_n(oe2_n), .address_select_pin(1'b1), .role_secondary(1'b1),
      .cascade_en(casc), .samp_clk_in(lclk), .samp_clk_out(sclk2), .sensor_in(touch2), .own_irq(own2),
      .int_in(int1), .int_out(int2), .wr_valid(wv2), .wr(wr2), .sensor_state_reg(st2));
   tsbc_master m_u (.clock(clock), .sda(sda), .scl(scl), .sda_drv_n(m_oe_n));
   ////////////////////////////////////////////////////////////////////////
   // system clock 100 MHz
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // link clock 32 ns, phase unrelated to the system clock
   initial begin
      lclk = 1'b0;
      #3.7;
      forever #16 lclk = ~lclk;
   end
   // catch write pulses, own-chip drive and both chips driving the line at once
   always @(posedge clock) begin
      if (wv1 === 1'b1 || wv2 === 1'b1) begin
         wr_last <= (wv1 === 1'b1) ? wr1 : wr2;
         nwr <= nwr + 1;
      end
      if (oe1_n === 1'b0 && so1 === 1'b0) drv1 <= 1'b1; // driven value must be low too
      if (oe1_n === 1'b0 && oe2_n === 1'b0) ovl <= 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk1(input string nm, input logic e, input logic g);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s: expected %b, seen %b", nm, e, g);
      end
   endtask
   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // strap is a level caught after release and role is read live, so set both in reset
   task automatic do_reset(input logic s, input logic r);
      rst_n = 1'b0;
      sel = s;
      role = r;
      repeat (2) @(negedge clock);
      rst_n = 1'b1;
      repeat (8) @(negedge clock);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_write();
      int n0;
      n0 = nwr;
      m_u.start();
      m_u.wbyte(8'h40, ack);
      chk1("write address ack", 1'b1, ack);
      m_u.wbyte(8'h5A, ack);
      chk1("command ack", 1'b1, ack);
      m_u.wbyte(8'hC3, ack);
      chk8("command", 8'h5A, wr_last.cmd);
      chk8("data", 8'hC3, wr_last.data);
      m_u.wbyte(8'h3C, ack);
      chk1("second data ack", 1'b1, ack);
      chk8("paired data", 8'h3C, wr_last.data);
      chk8("write count", 8'h02, 8'(nwr - n0));
      m_u.start();
      m_u.wbyte(8'h41, ack);
      chk1("restart ack", 1'b1, ack);
      m_u.rbyte(1'b0, rd);
      chk8("read after restart", touch1, rd);
      m_u.stop();
   endtask
   task automatic t_strap();
      do_reset(1'b1, 1'b0);
      m_u.start();
      m_u.wbyte(8'h40, ack);
      chk1("wrong address ack", 1'b0, ack);
      drv1 = 1'b0;
      m_u.start();
      m_u.wbyte(8'h42, ack);
      chk1("strapped select ack", 1'b1, drv1);
      m_u.stop();
      do_reset(1'b0, 1'b0);
   endtask
   task automatic t_read();
      touch1 = 8'h5C;
      repeat (30) @(negedge clock);
      chk8("primary state", 8'h5C, st1);
      m_u.start();
      m_u.wbyte(8'h41, ack);
      chk1("read address ack", 1'b1, ack);
      for (int i = 0; i < 3; i++) begin
         m_u.rbyte(i < 2, rd);
         chk8("repeated state", 8'h5C, rd);
      end
      m_u.stop();
      chk1("line after nack", 1'b1, sda);
   endtask
   // cascade read alternates chips, then a plain write reaches the secondary
   task automatic t_cascade();
      int n0;
      casc = 1'b1;
      touch1 = 8'h81;
      touch2 = 8'h7E;
      ovl = 1'b0;
      repeat (40) @(negedge clock);
      m_u.start();
      m_u.wbyte(8'h41, ack);
      chk1("cascade address ack", 1'b1, ack);
      for (int i = 0; i < 4; i++) begin
         m_u.rbyte(i < 3, rd);
         chk8("cascade byte", i[0] ? 8'h7E : 8'h81, rd);
      end
      m_u.stop();
      chk1("double drive seen", 1'b0, ovl);
      n0 = nwr;
      m_u.start();
      m_u.wbyte(8'h42, ack);
      m_u.wbyte(8'h11, ack);
      m_u.wbyte(8'h22, ack);
      m_u.stop();
      chk8("secondary data", 8'h22, wr_last.data);
      chk8("secondary writes", 8'h01, 8'(nwr - n0));
      casc = 1'b0;
   endtask
   task automatic t_sampclk();
      time t0;
      @(posedge sclk1);
      t0 = $time;
      @(posedge sclk1);
      chk8("sample clock period", 8'(2 * SH), 8'(($time - t0) / 10));
      @(negedge clock);
      touch2 = 8'h4D;
      repeat (40) begin
         @(negedge clock);
         chk1("secondary clock out", 1'b0, sclk2);
      end
      chk8("secondary state", 8'h4D, st2);
      do_reset(1'b0, 1'b1);
      touch1 = 8'hE7;
      repeat (40) @(negedge clock);
      chk1("role clock out", 1'b0, sclk1);
      chk8("state without received clock", STATE_RST, st1);
      do_reset(1'b0, 1'b0);
   endtask
   // chain: bench pin into primary, primary out into secondary
   task automatic t_irq();
      for (int i = 0; i < 8; i++) begin
         {irq_in, own1, own2} = i[2:0];
         repeat (8) @(negedge clock);
         chk1("primary interrupt", i[2] | i[1], int1);
         chk1("chained interrupt", |i[2:0], int2);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk_en = 1'b1;
      casc = 1'b0;
      touch1 = 8'hA5;
      touch2 = 8'h00;
      own1 = 1'b0;
      own2 = 1'b0;
      irq_in = 1'b0;
      ovl = 1'b0;
      drv1 = 1'b0;
      fails = 0;
      samples_checked = 0;
      nwr = 0;
      do_reset(1'b0, 1'b0);
      t_write();
      t_strap();
      t_read();
      t_cascade();
      t_sampclk();
      t_irq();
      end_of_test();
   end
   // watchdog well past the expected run of some 4000 cycles
   initial begin
      #500000;
      fails++;
      end_of_test();
   end
endmodule

// File: tsbc_fifo.sv
// small buffer for sensor-state words between sampler and bus side
`timescale 1ns/1ps
module tsbc_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 2
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } tsbc_fq_t;

   tsbc_fq_t q, d;
   logic push, pop;

   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // honest full and empty straight from the fill count
   assign in_ready = (q.cnt != (AW + 1)'(DEPTH));
   assign out_valid = (q.cnt != '0);
   assign out_data = q.mem[q.rp];
   assign push = clk_en && in_valid && in_ready;
   assign pop = clk_en && out_valid && out_ready;

   // pointer and count update
   always_comb begin
      d = q;
      if (push) begin
         d.mem[q.wp] = in_data;
         d.wp = ptr_inc(q.wp);
      end
      if (pop) begin
         d.rp = ptr_inc(q.rp);
      end
      case ({push, pop})
         2'h2: d.cnt = q.cnt + 1'b1;
         2'h1: d.cnt = q.cnt - 1'b1;
         default: d.cnt = q.cnt;
      endcase
   end

   // state register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule

// File: tsbc_master.sv
// behavioural bus master that drives the clock and pulls the data line
`timescale 1ns/1ps
module tsbc_master (
   input wire logic clock,
   input wire logic sda,
   output logic scl,
   output logic sda_drv_n
);
   // idle bus: both lines high
   initial begin
      scl = 1'b1;
      sda_drv_n = 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////
   // wait n system clocks, always landing on a falling edge
   task automatic w(input int n);
      repeat (n) @(negedge clock);
   endtask
   // start or repeated start, data falls while clock high
   task automatic start();
      sda_drv_n = 1'b1;
      w(5);
      scl = 1'b1;
      w(5);
      sda_drv_n = 1'b0;
      w(5);
      scl = 1'b0;
   endtask
   // one bit; data moves 3 clocks after the fall, after the slave at 2.5
   task automatic bit_io(input logic b, output logic r);
      w(3);
      sda_drv_n = b;
      w(7);
      scl = 1'b1;
      w(5);
      r = sda;
      w(5);
      scl = 1'b0;
   endtask
   // address, command and data bytes, each followed by the slave ack
   task automatic wbyte(input logic [7:0] v, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(v[i], r);
      end
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   // read a byte; no ack on the last one before stop
   task automatic rbyte(input logic ack, output logic [7:0] v);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         v[i] = r;
      end
      bit_io(~ack, r);
   endtask
   // stop: data rises while clock high
   task automatic stop();
      w(3);
      sda_drv_n = 1'b0;
      w(7);
      scl = 1'b1;
      w(5);
      sda_drv_n = 1'b1;
      w(10);
   endtask
endmodule

// File: tsbc_pkg.sv
// shared constants and types for the touch sensor bus front end
package tsbc_pkg;
   localparam int STATE_W = 8;
   localparam logic [5:0] ADDR_FIXED = 6'h10;
   localparam int RW_BIT = 0;
   localparam int SEL_BIT = 1;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [STATE_W-1:0] STATE_RST = 8'h00;
   localparam int FIFO_DEPTH = 2;
   localparam int SAMP_HALF_CYC = 16;
   localparam int SAMP_DIV_W = 8;
   localparam logic [1:0] STRAP_WAIT = 2'h3; // two sync edges, then the latch edge

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_ADDR = 4'h1,
      ST_ADDR_ACK = 4'h2,
      ST_CMD = 4'h3,
      ST_CMD_ACK = 4'h4,
      ST_DATA = 4'h5,
      ST_DATA_ACK = 4'h6,
      ST_TX = 4'h7,
      ST_TX_ACK = 4'h8
   } tsbc_state_t;

   typedef struct packed {
      logic [7:0] cmd;
      logic [7:0] data;
   } tsbc_wr_t;
endpackage

// File: tsbc_slave.sv
// bus slave, sensor-state read path and two-chip cascade logic
`timescale 1ns/1ps
module tsbc_slave #(
   parameter int SAMP_HALF = tsbc_pkg::SAMP_HALF_CYC
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n,
   input wire logic address_select_pin,
   input wire logic role_secondary,
   input wire logic cascade_en,
   input wire logic samp_clk_in,
   output logic samp_clk_out,
   input wire logic [tsbc_pkg::STATE_W-1:0] sensor_in,
   input wire logic own_irq,
   input wire logic int_in,
   output logic int_out,
   output logic wr_valid,
   output tsbc_pkg::tsbc_wr_t wr,
   output logic [tsbc_pkg::STATE_W-1:0] sensor_state_reg
);
   import tsbc_pkg::*;

   typedef struct packed {
      logic scl_m, scl_s, scl_p;
      logic sda_m, sda_s, sda_p;
      logic strap_m, strap_s, strap_bit;
      logic [1:0] strap_cnt;
      logic int_m, int_s, int_out;
      logic req_m, req_s, ack;
      tsbc_state_t st;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic rw, alt, slot, acked, oe_n;
      logic [7:0] cmd;
      tsbc_wr_t wr;
      logic wr_valid;
      logic [STATE_W-1:0] held;
      logic [SAMP_DIV_W-1:0] div;
      logic sclk;
      logic [STATE_W-1:0] sen_m, sen_s, pword;
      logic pend;
   } tsbc_q_t;

   typedef struct packed {
      logic ack_m, ack_s, req;
      logic [STATE_W-1:0] raw_m, raw_s;
      logic [STATE_W-1:0] word;
   } tsbc_lq_t;

   tsbc_q_t q, d;
   tsbc_lq_t lq, ld;
   logic rise_e, fall_e, start_e, stop_e;
   logic src_valid, src_ready, drain, fifo_valid;
   logic [STATE_W-1:0] src_data, fifo_data;
   logic own_hit, shared_hit;

   // true when this chip owns the current read byte slot
   function automatic logic tx_mine(input logic alt, input logic slot, input logic sec);
      tx_mine = !alt || (slot == sec);
   endfunction

   ////////////////////////////////////////////////////////////////////
   // link side: secondary samples on the falling edge of the primary clock
   always_comb begin
      ld = lq;
      ld.ack_m = q.ack;
      ld.ack_s = lq.ack_m;
      ld.raw_m = sensor_in; // pins pass two link-side flops first
      ld.raw_s = lq.raw_m;
      // a new word only after the last one was taken, so the word stays stable
      if (lq.ack_s == lq.req) begin
         ld.word = lq.raw_s;
         ld.req = !lq.req;
      end
   end

   // inverted received clock: never samples together with the primary
   always_ff @(negedge samp_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         lq <= '0;
      end else begin
         lq <= ld;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // bus line events from the second sync stage and its delayed copy
   assign rise_e = q.scl_s && !q.scl_p;
   assign fall_e = !q.scl_s && q.scl_p;
   assign start_e = q.scl_s && q.scl_p && q.sda_p && !q.sda_s;
   assign stop_e = q.scl_s && q.scl_p && !q.sda_p && q.sda_s;
   assign own_hit = (q.sh[7:1] == {ADDR_FIXED, q.strap_bit});
   assign shared_hit = cascade_en && role_secondary && q.sh[RW_BIT] && (q.sh[7:1] == {ADDR_FIXED, 1'b0});

   // word source: own sampler as primary, handshake word as secondary
   assign src_valid = role_secondary ? (q.req_s != q.ack) : q.pend;
   assign src_data = role_secondary ? lq.word : q.pword;
   // sensor state must not change while a byte is being shifted out
   assign drain = (q.st != ST_TX);

   tsbc_fifo #(
      .W(STATE_W),
      .DEPTH(FIFO_DEPTH)
   ) u_buf (
      .clock(clock),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .in_valid(src_valid),
      .in_ready(src_ready),
      .in_data(src_data),
      .out_valid(fifo_valid),
      .out_ready(drain),
      .out_data(fifo_data)
   );

   ////////////////////////////////////////////////////////////////////
   // next state of the whole system-clock side
   always_comb begin
      d = q;
      if (clk_en) begin
         d.scl_m = scl_i;
         d.scl_s = q.scl_m;
         d.scl_p = q.scl_s;
         d.sda_m = sda_i;
         d.sda_s = q.sda_m;
         d.sda_p = q.sda_s;
         d.strap_m = address_select_pin;
         d.strap_s = q.strap_m;
         d.int_m = int_in;
         d.int_s = q.int_m;
         d.req_m = lq.req;
         d.req_s = q.req_m;
         d.sen_m = sensor_in;
         d.sen_s = q.sen_m;
         d.wr_valid = 1'b0;
         // strap caught once, after the sync stages have filled
         if (q.strap_cnt != STRAP_WAIT) begin
            d.strap_cnt = q.strap_cnt + 2'h1;
            d.strap_bit = q.strap_s;
         end
         d.int_out = own_irq || q.int_s;
         // taken word frees the source before a new sample is considered
         if (src_valid && src_ready) begin
            if (role_secondary) begin
               d.ack = !q.ack;
            end else begin
               d.pend = 1'b0;
            end
         end
         // internal sample clock, driven out only by a primary
         if (role_secondary) begin
            d.sclk = 1'b0;
            d.div = '0;
         end else if (q.div == SAMP_DIV_W'(SAMP_HALF - 1)) begin
            d.div = '0;
            d.sclk = !q.sclk;
            if (!q.sclk && !d.pend) begin
               d.pword = q.sen_s;
               d.pend = 1'b1;
            end
         end else begin
            d.div = q.div + 1'b1;
         end
         if (fifo_valid && drain) begin
            d.held = fifo_data;
         end
         // bus sequencer; start and stop override any state
         if (start_e) begin
            d.st = ST_ADDR;
            d.cnt = '0;
            d.oe_n = 1'b1;
            d.slot = 1'b0;
         end else if (stop_e) begin
            d.st = ST_IDLE;
            d.oe_n = 1'b1;
         end else begin
            case (q.st)
               ST_ADDR, ST_CMD, ST_DATA: begin
                  if (rise_e) begin
                     d.sh = {q.sh[6:0], q.sda_s};
                     d.cnt = q.cnt + 4'h1;
                  end else if (fall_e && q.cnt == BYTE_BITS) begin
                     d.cnt = '0;
                     d.oe_n = 1'b0;
                     if (q.st == ST_ADDR) begin
                        d.rw = q.sh[RW_BIT];
                        d.alt = cascade_en && q.sh[RW_BIT] && (q.sh[7:1] == {ADDR_FIXED, 1'b0});
                        if (own_hit) begin
                           d.st = ST_ADDR_ACK;
                        end else if (shared_hit) begin
                           d.st = ST_ADDR_ACK;
                           d.oe_n = 1'b1;
                        end else begin
                           d.st = ST_IDLE;
                           d.oe_n = 1'b1;
                        end
                     end else if (q.st == ST_CMD) begin
                        d.cmd = q.sh;
                        d.st = ST_CMD_ACK;
                     end else begin
                        d.wr.cmd = q.cmd;
                        d.wr.data = q.sh;
                        d.wr_valid = 1'b1;
                        d.st = ST_DATA_ACK;
                     end
                  end
               end
               ST_ADDR_ACK, ST_CMD_ACK, ST_DATA_ACK: begin
                  if (fall_e) begin
                     d.oe_n = 1'b1;
                     d.cnt = '0;
                     if (q.st == ST_ADDR_ACK && q.rw) begin
                        d.st = ST_TX;
                        d.sh = q.held;
                        d.oe_n = !(tx_mine(q.alt, 1'b0, role_secondary) && !q.held[7]);
                     end else begin
                        d.st = (q.st == ST_ADDR_ACK) ? ST_CMD : ST_DATA;
                     end
                  end
               end
               ST_TX: begin
                  if (rise_e) begin
                     d.cnt = q.cnt + 4'h1;
                  end else if (fall_e) begin
                     if (q.cnt == BYTE_BITS) begin
                        d.st = ST_TX_ACK;
                        d.oe_n = 1'b1;
                     end else begin
                        d.sh = {q.sh[6:0], 1'b0};
                        d.oe_n = !(tx_mine(q.alt, q.slot, role_secondary) && !q.sh[6]);
                     end
                  end
               end
               ST_TX_ACK: begin
                  if (rise_e) begin
                     d.acked = !q.sda_s;
                  end else if (fall_e) begin
                     if (q.acked) begin
                        d.st = ST_TX;
                        d.cnt = '0;
                        d.slot = q.slot ^ q.alt;
                        d.sh = q.held;
                        d.oe_n = !(tx_mine(q.alt, q.slot ^ q.alt, role_secondary) && !q.held[7]);
                     end else begin
                        d.st = ST_IDLE;
                     end
                  end
               end
               default: begin
                  d.st = ST_IDLE;
               end
            endcase
         end
      end
   end

   // register of all system-clock state; lines idle high at reset
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
         q.scl_m <= 1'b1;
         q.scl_s <= 1'b1;
         q.scl_p <= 1'b1;
         q.sda_m <= 1'b1;
         q.sda_s <= 1'b1;
         q.sda_p <= 1'b1;
         q.oe_n <= 1'b1;
         q.st <= ST_IDLE;
         q.held <= STATE_RST;
      end else begin
         q <= d;
      end
   end

   // open drain: value is low whenever the enable is active
   assign sda_o = q.oe_n;
   assign sda_oe_n = q.oe_n;
   assign samp_clk_out = q.sclk;
   assign int_out = q.int_out;
   assign wr_valid = q.wr_valid;
   assign wr = q.wr;
   assign sensor_state_reg = q.held;

   ////////////////////////////////////////////////////////////////////
   // checks on the system-clock side
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   property p_addr_ack;
      clk_en && fall_e && q.st == ST_ADDR && q.cnt == BYTE_BITS && own_hit |=> !sda_oe_n && q.st == ST_ADDR_ACK;
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged");

   property p_cmd_ack;
      clk_en && fall_e && q.st == ST_CMD && q.cnt == BYTE_BITS |=> !sda_oe_n ##1 q.st == ST_CMD_ACK;
   endproperty
   a_cmd_ack: assert property (p_cmd_ack) else $error("command byte not acknowledged");

   property p_data_strobe;
      clk_en && fall_e && q.st == ST_DATA && q.cnt == BYTE_BITS |=> wr_valid && wr.data == $past(q.sh) && !sda_oe_n;
   endproperty
   a_data_strobe: assert property (p_data_strobe) else $error("data byte not delivered");

   property p_restart;
      clk_en && start_e |=> q.st == ST_ADDR && sda_oe_n && q.cnt == 4'h0;
   endproperty
   a_restart: assert property (p_restart) else $error("start did not open a new access");

   property p_stop;
      clk_en && stop_e |=> q.st == ST_IDLE && sda_oe_n;
   endproperty
   a_stop: assert property (p_stop) else $error("stop did not release the bus");

   property p_direct_read;
      clk_en && fall_e && q.st == ST_ADDR_ACK && q.rw && !q.alt |=> q.st == ST_TX && sda_oe_n == $past(q.held[7]);
   endproperty
   a_direct_read: assert property (p_direct_read) else $error("sensor state not sent after address");

   property p_repeat;
      clk_en && fall_e && q.st == ST_TX_ACK && q.acked |=> q.st == ST_TX && q.sh == $past(q.held);
   endproperty
   a_repeat: assert property (p_repeat) else $error("sensor state not resent after ack");

   property p_alternate;
      clk_en && fall_e && q.st == ST_TX_ACK && q.acked && q.alt |=> q.slot != $past(q.slot);
   endproperty
   a_alternate: assert property (p_alternate) else $error("cascade slot did not alternate");

   property p_quiet;
      q.st == ST_TX && !tx_mine(q.alt, q.slot, role_secondary) && $stable(role_secondary) |-> sda_oe_n;
   endproperty
   a_quiet: assert property (p_quiet) else $error("data driven in other chip slot");

   property p_shared;
      clk_en && fall_e && q.st == ST_ADDR && q.cnt == BYTE_BITS && shared_hit && !own_hit |=> q.st == ST_ADDR_ACK && sda_oe_n;
   endproperty
   a_shared: assert property (p_shared) else $error("secondary ignored shared read address");

   property p_int_or;
      $past(clk_en) |-> int_out == $past(own_irq || q.int_s);
   endproperty
   a_int_or: assert property (p_int_or) else $error("interrupt out is not the OR");

   cover property (clk_en && fall_e && q.st == ST_TX_ACK && q.acked && !q.alt);
   cover property (wr_valid);
   cover property (clk_en && fall_e && q.st == ST_TX_ACK && q.acked && q.alt);
   cover property (clk_en && role_secondary && src_valid && src_ready);
endmodule
